// ===== rtl/omc_pkg.sv
// operating mode controller: shared constants, register map and mode codes
// assumes a 125 MHz system clock and the plain strobe register port
// ==========================================================================
// Function
// - wake from direct inputs or wake pin
// - fail from supervisor failure or fallback input
// - both supplies low means power off
// - sleep until wake, outputs disabled
// - normal when wake and no fail, from fail only after toggles
// - normal channels from on bit or input
// - channel rising edge restarts overcurrent window
// - fail: outputs follow inputs, external off
// - fail: latched readout select, no sensing
// - fail: maximum overcurrent profile on all
// - fail: overload or undervoltage auto restarts
// - fail: severe faults latch off until wake
// - fail: inputs control channels and windows
// - wake clears registers, blanks faults
// - initialization done fifty microseconds after wake
// - fail entry immediate, clears input settings
// - diagnosis usable unless data lines stuck
// - fail return needs cause gone, toggles
// - return clears registers, sets status flags
// - status read clears registers-cleared flag
// - readback needs logic supply present
package omc_pkg;
   localparam int unsigned NCH = 4;
   localparam int unsigned AW  = 8;
   localparam int unsigned DW  = 32;
   localparam int unsigned TW  = 16;

   // ==========================================================================
   // timing
   localparam int unsigned CLK_PERIOD_NS    = 8;
   localparam int unsigned INIT_TIME_NS     = 50000;
   localparam int unsigned BLANK_TIME_NS    = 1000;
   localparam int unsigned TOGGLE_PERIOD_NS = 100000;
   localparam int unsigned INIT_CYC_DEF     = INIT_TIME_NS / CLK_PERIOD_NS;
   localparam int unsigned BLANK_CYC_DEF    = BLANK_TIME_NS / CLK_PERIOD_NS;
   localparam int unsigned TOGGLE_CYC_DEF   = TOGGLE_PERIOD_NS / CLK_PERIOD_NS;

   // ==========================================================================
   // register map
   localparam logic [AW-1:0] REG_CHAN_ON = 8'h00;
   localparam logic [AW-1:0] REG_IN_EN   = 8'h04;
   localparam logic [AW-1:0] REG_SEL     = 8'h08;
   localparam logic [AW-1:0] REG_CMD     = 8'h0c;
   localparam logic [AW-1:0] REG_STATUS  = 8'h10;

   localparam int unsigned EXT_BIT  = 4;
   localparam int unsigned SEL_W    = 4;
   localparam int unsigned TOG_BIT  = 0;
   localparam int unsigned ST_DSF   = 2;
   localparam int unsigned ST_RCF   = 3;
   localparam int unsigned ST_INIT  = 4;
   localparam int unsigned ST_DIAG  = 5;
   localparam int unsigned ST_LATCH = 6;
   localparam int unsigned ST_SEL   = 10;

   typedef enum logic [1:0] {
      MODE_OFF    = 2'b00,
      MODE_SLEEP  = 2'b01,
      MODE_NORMAL = 2'b10,
      MODE_FAIL   = 2'b11
   } omc_mode_t;

   function automatic logic [NCH-1:0] omc_rise(input logic [NCH-1:0] cur,
                                               input logic [NCH-1:0] prev);
      omc_rise = cur & ~prev;
   endfunction
endpackage

// ===== rtl/omc_sync.sv
// omc_sync: three-stage synchroniser with agreement filter
// assumes inputs asynchronous to clk_sys_i
`timescale 1ns/1ps
`default_nettype none
module omc_sync #(
   parameter int unsigned W = 1
) (
   input  wire logic         clk_sys_i,
   input  wire logic         srst_i,
   input  wire logic [W-1:0] async_i,
   output logic      [W-1:0] sync_o
);
   logic [W-1:0] s1;
   logic [W-1:0] s2;
   logic [W-1:0] s3;

   always_ff @(posedge clk_sys_i) begin
      if (srst_i) begin
         s1 <= '0;
         s2 <= '0;
         s3 <= '0;
      end else begin
         s1 <= async_i;
         s2 <= s1;
         s3 <= s2;
      end
   end

   // a change counts only once stages two and three agree
   always_ff @(posedge clk_sys_i) begin
      if (srst_i) begin
         sync_o <= '0;
      end else begin
         sync_o <= (s2 & s3) | (sync_o & (s2 | s3));
      end
   end
endmodule
`default_nettype wire

// ===== rtl/omc_timer.sv
// omc_timer: loadable down counter, busy while running
// assumes load is a one-cycle pulse from the same clock
`timescale 1ns/1ps
`default_nettype none
module omc_timer #(
   parameter int unsigned W   = 16,
   parameter int unsigned CYC = 1
) (
   input  wire logic clk_sys_i,
   input  wire logic srst_i,
   input  wire logic load_i,
   input  wire logic stop_i,
   output logic      busy_o
);
   logic [W-1:0] cnt;

   always_ff @(posedge clk_sys_i) begin
      if (srst_i || stop_i) begin
         cnt <= '0;
      end else if (load_i) begin
         cnt <= W'(CYC);
      end else if (cnt != '0) begin
         cnt <= cnt - W'(1);
      end
   end

   assign busy_o = (cnt != '0);
endmodule
`default_nettype wire

// ===== rtl/omc_top.sv
// omc_top: operating mode controller of the lighting switch
// assumes supervisor and fault flags on clk_sys_i; pins and supply flags async
//
// Our own choices: the address-and-strobe port and the register offsets.
`timescale 1ns/1ps
`default_nettype none
module omc_top #(
   parameter int unsigned INIT_CYC   = omc_pkg::INIT_CYC_DEF,
   parameter int unsigned BLANK_CYC  = omc_pkg::BLANK_CYC_DEF,
   parameter int unsigned TOGGLE_CYC = omc_pkg::TOGGLE_CYC_DEF
) (
   input  wire logic                     clk_sys_i,
   input  wire logic                     srst_i,
   // pins and supply comparators
   input  wire logic [omc_pkg::NCH-1:0]  direct_control_inputs_i,
   input  wire logic                     active_low_wake_pin_n_i,
   input  wire logic                     fallback_input_i,
   input  wire logic                     battery_por_ok_i,
   input  wire logic                     logic_por_ok_i,
   // serial supervisor
   input  wire logic                     spi_fail_i,
   input  wire logic                     spi_stuck_i,
   // per-channel protection events
   input  wire logic [omc_pkg::NCH-1:0]  overload_i,
   input  wire logic [omc_pkg::NCH-1:0]  undervoltage_i,
   input  wire logic [omc_pkg::NCH-1:0]  overtemp_i,
   input  wire logic [omc_pkg::NCH-1:0]  first_high_overcurrent_level_i,
   input  wire logic [omc_pkg::NCH-1:0]  severe_short_i,
   // register port
   input  wire logic [omc_pkg::AW-1:0]   reg_addr_i,
   input  wire logic [omc_pkg::DW-1:0]   reg_wdata_i,
   input  wire logic                     reg_wr_i,
   input  wire logic                     reg_rd_i,
   output logic      [omc_pkg::DW-1:0]   reg_rdata_o,
   // block outputs
   output omc_pkg::omc_mode_t            mode_o,
   output logic      [omc_pkg::NCH-1:0]  power_outputs_o,
   output logic                          external_switch_output_o,
   output logic      [omc_pkg::NCH-1:0]  window_restart_o,
   output logic      [omc_pkg::NCH-1:0]  autorestart_o,
   output logic                          pwm_enable_o,
   output logic                          current_sense_output_en_o,
   output logic                          max_oc_profile_o,
   output logic      [omc_pkg::SEL_W-1:0] readout_select_bits_o,
   output logic                          diag_avail_o,
   output logic                          fault_suppress_o,
   output logic                          init_done_o,
   output logic                          por_clear_o
);
   import omc_pkg::*;

   // ==========================================================================
   // input synchronisation
   logic [NCH+3:0] pin_s;
   logic [NCH-1:0] direct_input_on_state;
   logic           wake_pin_s;
   logic           fallback_s;
   logic           bat_ok_s;
   logic           log_ok_s;

   omc_sync #(.W(NCH + 4)) u_sync (
      .clk_sys_i (clk_sys_i),
      .srst_i    (srst_i),
      .async_i   ({logic_por_ok_i, battery_por_ok_i, fallback_input_i,
                   active_low_wake_pin_n_i, direct_control_inputs_i}),
      .sync_o    (pin_s)
   );

   assign direct_input_on_state = pin_s[NCH-1:0];
   assign wake_pin_s            = pin_s[NCH];
   assign fallback_s            = pin_s[NCH+1];
   assign bat_ok_s              = pin_s[NCH+2];
   assign log_ok_s              = pin_s[NCH+3];

   logic wake_c;
   logic fail_c;
   assign wake_c = (|direct_input_on_state) | wake_pin_s;
   assign fail_c = spi_fail_i | fallback_s;

   // ==========================================================================
   // mode sequencing
   omc_mode_t mode;
   omc_mode_t next_mode;
   logic      toggle_ok;
   logic      wake_evt;
   logic      fail_entry;
   logic      return_evt;

   always_comb begin
      next_mode = mode;
      if (!bat_ok_s && !log_ok_s) begin
         next_mode = MODE_OFF;
      end else begin
         unique case (mode)
            MODE_OFF: begin
               next_mode = MODE_SLEEP;
            end
            MODE_SLEEP: begin
               if (wake_c) begin
                  next_mode = fail_c ? MODE_FAIL : MODE_NORMAL;
               end
            end
            MODE_NORMAL: begin
               if (!wake_c) begin
                  next_mode = MODE_SLEEP;
               end else if (fail_c) begin
                  next_mode = MODE_FAIL;
               end
            end
            MODE_FAIL: begin
               if (!wake_c) begin
                  next_mode = MODE_SLEEP;
               end else if (!fail_c && toggle_ok) begin
                  next_mode = MODE_NORMAL;
               end
            end
         endcase
      end
   end

   assign wake_evt   = (mode == MODE_SLEEP) && (next_mode != MODE_SLEEP)
                       && (next_mode != MODE_OFF);
   assign fail_entry = (mode == MODE_NORMAL) && (next_mode == MODE_FAIL);
   assign return_evt = (mode == MODE_FAIL) && (next_mode == MODE_NORMAL);

   always_ff @(posedge clk_sys_i) begin
      if (srst_i) begin
         mode <= MODE_OFF;
      end else begin
         mode <= next_mode;
      end
   end

   // ==========================================================================
   // timers: initialisation, fault blanking, toggle window
   logic init_busy;
   logic blank_busy;
   logic tog_busy;
   logic tog_arm;
   logic tog_start;
   logic wr_cmd;
   logic awake;

   assign awake  = (mode == MODE_NORMAL) || (mode == MODE_FAIL);
   assign wr_cmd = reg_wr_i && (reg_addr_i == REG_CMD);

   omc_timer #(.W(TW), .CYC(INIT_CYC)) u_init (
      .clk_sys_i (clk_sys_i),
      .srst_i    (srst_i),
      .load_i    (wake_evt),
      .stop_i    (1'b0),
      .busy_o    (init_busy)
   );

   omc_timer #(.W(TW), .CYC(BLANK_CYC)) u_blank (
      .clk_sys_i (clk_sys_i),
      .srst_i    (srst_i),
      .load_i    (wake_evt),
      .stop_i    (1'b0),
      .busy_o    (blank_busy)
   );

   // first toggle command at zero opens the window
   omc_timer #(.W(TW), .CYC(TOGGLE_CYC)) u_tog (
      .clk_sys_i (clk_sys_i),
      .srst_i    (srst_i),
      .load_i    (tog_start),
      .stop_i    (mode != MODE_FAIL),
      .busy_o    (tog_busy)
   );

   assign tog_start = (mode == MODE_FAIL) && !fail_c && wr_cmd
                      && !reg_wdata_i[TOG_BIT];
   assign toggle_ok = tog_arm && tog_busy && wr_cmd && reg_wdata_i[TOG_BIT];

   always_ff @(posedge clk_sys_i) begin
      if (srst_i || mode != MODE_FAIL || fail_c) begin
         tog_arm <= 1'b0;
      end else if (tog_start) begin
         tog_arm <= 1'b1;
      end else if (!tog_busy) begin
         tog_arm <= 1'b0;
      end
   end

   // ==========================================================================
   // serial input settings (cleared on wake, fail entry and return)
   logic [NCH-1:0]   chan_on;
   logic             ext_on;
   logic [NCH-1:0]   in_en;
   logic [SEL_W-1:0] sel_si;
   logic             si_clear;
   logic             so_clear;

   assign so_clear = wake_evt || return_evt;
   assign si_clear = so_clear || fail_entry || !awake;

   always_ff @(posedge clk_sys_i) begin
      if (srst_i || si_clear) begin
         chan_on <= '0;
         ext_on  <= 1'b0;
         in_en   <= '0;
         sel_si  <= '0;
      end else if (reg_wr_i && mode == MODE_NORMAL) begin
         unique case (reg_addr_i)
            REG_CHAN_ON: begin
               chan_on <= reg_wdata_i[NCH-1:0];
               ext_on  <= reg_wdata_i[EXT_BIT];
            end
            REG_IN_EN: begin
               in_en <= reg_wdata_i[NCH-1:0];
            end
            REG_SEL: begin
               sel_si <= reg_wdata_i[SEL_W-1:0];
            end
            default: begin
            end
         endcase
      end
   end

   // ==========================================================================
   // serial output state: kept through fail entry
   logic [SEL_W-1:0] sel_so;
   logic             device_status_flag;
   logic             registers_cleared_flag;
   logic             stuck_seen;
   logic             rd_status;
   logic             diag_ok;

   assign rd_status = reg_rd_i && (reg_addr_i == REG_STATUS);
   // a stuck cause hides diagnosis from the first fail cycle on
   assign diag_ok   = (mode == MODE_FAIL) && !stuck_seen
                      && !(spi_stuck_i && spi_fail_i);

   always_ff @(posedge clk_sys_i) begin
      if (srst_i || wake_evt) begin
         sel_so <= '0;
         device_status_flag    <= 1'b0;
      end else if (return_evt) begin
         sel_so <= '0;
         device_status_flag    <= 1'b1;
      end else if (mode == MODE_NORMAL && reg_wr_i && reg_addr_i == REG_SEL) begin
         sel_so <= reg_wdata_i[SEL_W-1:0];
      end
   end

   // set wins over a read in the same cycle
   always_ff @(posedge clk_sys_i) begin
      if (srst_i || wake_evt) begin
         registers_cleared_flag <= 1'b0;
      end else if (return_evt) begin
         registers_cleared_flag <= 1'b1;
      end else if (rd_status) begin
         registers_cleared_flag <= 1'b0;
      end
   end

   always_ff @(posedge clk_sys_i) begin
      if (srst_i || mode != MODE_FAIL) begin
         stuck_seen <= 1'b0;
      end else if (spi_stuck_i && spi_fail_i) begin
         stuck_seen <= 1'b1;
      end
   end

   // ==========================================================================
   // channel control and fail-mode protection
   logic [NCH-1:0] latched_off;
   logic [NCH-1:0] ch_ctl;
   logic [NCH-1:0] ch_prev;
   logic [NCH-1:0] in_prev;
   logic [NCH-1:0] hard_fault;
   logic [NCH-1:0] soft_fault;

   assign hard_fault = overtemp_i | first_high_overcurrent_level_i | severe_short_i;
   assign soft_fault = overload_i | undervoltage_i;

   // faults are ignored while blanked after wake
   always_ff @(posedge clk_sys_i) begin
      if (srst_i || wake_evt) begin
         latched_off <= '0;
      end else if (mode == MODE_FAIL && !blank_busy) begin
         latched_off <= latched_off | hard_fault;
      end
   end

   always_comb begin
      unique case (mode)
         MODE_NORMAL: ch_ctl = chan_on | (in_en & direct_input_on_state);
         MODE_FAIL:   ch_ctl = direct_input_on_state & ~latched_off;
         default:     ch_ctl = '0;
      endcase
   end

   always_ff @(posedge clk_sys_i) begin
      if (srst_i) begin
         ch_prev <= '0;
         in_prev <= '0;
      end else begin
         ch_prev <= ch_ctl;
         in_prev <= direct_input_on_state;
      end
   end

   // ==========================================================================
   // registered outputs
   always_ff @(posedge clk_sys_i) begin
      if (srst_i) begin
         mode_o                    <= MODE_OFF;
         power_outputs_o           <= '0;
         external_switch_output_o  <= 1'b0;
         window_restart_o          <= '0;
         autorestart_o             <= '0;
         pwm_enable_o              <= 1'b0;
         current_sense_output_en_o <= 1'b0;
         max_oc_profile_o          <= 1'b0;
         readout_select_bits_o     <= '0;
         diag_avail_o              <= 1'b0;
         fault_suppress_o          <= 1'b0;
         init_done_o               <= 1'b0;
         por_clear_o               <= 1'b0;
      end else begin
         mode_o                    <= mode;
         power_outputs_o           <= ch_ctl;
         external_switch_output_o  <= (mode == MODE_NORMAL) && ext_on;
         if (mode == MODE_FAIL) begin
            window_restart_o <= omc_rise(direct_input_on_state, in_prev);
         end else begin
            window_restart_o <= omc_rise(ch_ctl, ch_prev);
         end
         autorestart_o             <= (mode == MODE_FAIL) ? soft_fault & ~latched_off
                                                          : '0;
         pwm_enable_o              <= (mode == MODE_NORMAL);
         current_sense_output_en_o <= (mode == MODE_NORMAL);
         max_oc_profile_o          <= (mode == MODE_FAIL);
         readout_select_bits_o     <= sel_so;
         diag_avail_o              <= diag_ok;
         fault_suppress_o          <= blank_busy;
         init_done_o               <= awake && !init_busy;
         por_clear_o               <= so_clear;
      end
   end

   // ==========================================================================
   // register read, one cycle after the strobe; dead without logic supply
   always_ff @(posedge clk_sys_i) begin
      if (srst_i || !reg_rd_i || !log_ok_s) begin
         reg_rdata_o <= '0;
      end else begin
         reg_rdata_o <= '0;
         unique case (reg_addr_i)
            REG_CHAN_ON: begin
               reg_rdata_o[NCH-1:0]  <= chan_on;
               reg_rdata_o[EXT_BIT]  <= ext_on;
            end
            REG_IN_EN: begin
               reg_rdata_o[NCH-1:0] <= in_en;
            end
            REG_SEL: begin
               reg_rdata_o[SEL_W-1:0] <= sel_si;
            end
            REG_STATUS: begin
               reg_rdata_o[1:0]                   <= mode;
               reg_rdata_o[ST_DSF]                <= device_status_flag;
               reg_rdata_o[ST_RCF]                <= registers_cleared_flag;
               reg_rdata_o[ST_INIT]               <= awake && !init_busy;
               reg_rdata_o[ST_DIAG]               <= diag_ok;
               reg_rdata_o[ST_LATCH +: NCH]       <= latched_off;
               reg_rdata_o[ST_SEL +: SEL_W]       <= sel_so;
            end
            default: begin
            end
         endcase
      end
   end

   // ==========================================================================
   // checks
   property p_off;
      @(posedge clk_sys_i) disable iff (srst_i)
      (!bat_ok_s && !log_ok_s) |=> (mode == MODE_OFF);
   endproperty
   a_off: assert property (p_off) else $error("supplies low but not off");

   property p_sleep_exit;
      @(posedge clk_sys_i) disable iff (srst_i)
      (mode == MODE_SLEEP && (bat_ok_s || log_ok_s)) |=> ((mode != MODE_SLEEP) == $past(wake_c));
   endproperty
   a_sleep_exit: assert property (p_sleep_exit) else $error("sleep exit mismatch");

   property p_fail_entry;
      @(posedge clk_sys_i) disable iff (srst_i)
      (mode == MODE_NORMAL && wake_c && fail_c && (bat_ok_s || log_ok_s))
      |=> (mode == MODE_FAIL) && (chan_on == '0);
   endproperty
   a_fail_entry: assert property (p_fail_entry) else $error("fail entry late");

   property p_fail_outputs;
      @(posedge clk_sys_i) disable iff (srst_i)
      (mode == MODE_FAIL) |=> !external_switch_output_o && !pwm_enable_o
      && (power_outputs_o == ($past(direct_input_on_state) & ~$past(latched_off)));
   endproperty
   a_fail_outputs: assert property (p_fail_outputs) else $error("fail outputs wrong");

   property p_fail_profile;
      @(posedge clk_sys_i) disable iff (srst_i)
      (mode == MODE_FAIL) |=> max_oc_profile_o && !current_sense_output_en_o;
   endproperty
   a_fail_profile: assert property (p_fail_profile) else $error("fail profile wrong");

   property p_latch_hold;
      @(posedge clk_sys_i) disable iff (srst_i)
      (latched_off[0] && !wake_evt) |=> latched_off[0];
   endproperty
   a_latch_hold: assert property (p_latch_hold) else $error("latch released early");

   property p_rcf_clear;
      @(posedge clk_sys_i) disable iff (srst_i)
      (rd_status && !return_evt) |=> !registers_cleared_flag;
   endproperty
   a_rcf_clear: assert property (p_rcf_clear) else $error("status read kept flag");

   property p_return;
      @(posedge clk_sys_i) disable iff (srst_i)
      return_evt |=> registers_cleared_flag && device_status_flag && (mode == MODE_NORMAL) && por_clear_o;
   endproperty
   a_return: assert property (p_return) else $error("return flags missing");

   property p_readback;
      @(posedge clk_sys_i) disable iff (srst_i)
      !log_ok_s |=> (reg_rdata_o == '0);
   endproperty
   a_readback: assert property (p_readback) else $error("readback without supply");

   property p_init;
      @(posedge clk_sys_i) disable iff (srst_i)
      wake_evt |=> ##1 !init_done_o [*8];
   endproperty
   a_init: assert property (p_init) else $error("init done too early");

   c_wake:   cover property (@(posedge clk_sys_i) disable iff (srst_i) wake_evt);
   c_fail:   cover property (@(posedge clk_sys_i) disable iff (srst_i) fail_entry);
   c_return: cover property (@(posedge clk_sys_i) disable iff (srst_i) return_evt);
endmodule
`default_nettype wire

// ===== dv/omc_host_model.sv
// omc_host_model: host side, master of the plain register port
// assumes its tasks are entered right after a rising clock edge
`timescale 1ns/1ps
`default_nettype none
module omc_host_model (
   input  wire logic                   clk_sys_i,
   input  wire logic [omc_pkg::DW-1:0] rdata_i,
   output logic      [omc_pkg::AW-1:0] addr_o = '0,
   output logic      [omc_pkg::DW-1:0] wdata_o = '0,
   output logic                        wr_o = 1'b0,
   output logic                        rd_o = 1'b0
);
   import omc_pkg::*;
   // ==========================================================================
   // bus cycles
   // idle edge after a write so a strobe is never lowered and raised at once
   task automatic wr(input logic [AW-1:0] a, input logic [DW-1:0] d);
      addr_o <= a;
      wdata_o <= d;
      wr_o <= 1'b1;
      @(posedge clk_sys_i);
      wr_o <= 1'b0;
      @(posedge clk_sys_i);
   endtask
   // answer is taken one edge after the edge that closes its only cycle
   task automatic rd(input logic [AW-1:0] a, output logic [DW-1:0] d);
      addr_o <= a;
      rd_o <= 1'b1;
      @(posedge clk_sys_i);
      rd_o <= 1'b0;
      @(posedge clk_sys_i);
      d = rdata_i;
   endtask
   task automatic toggle_pair();
      wr(REG_CMD, 32'h0);
      wr(REG_CMD, 32'h1);
   endtask
endmodule
`default_nettype wire

// ===== dv/operating_mode_controller_test.sv
// operating_mode_controller_test: self-checking bench for omc_top
// assumes omc_host_model as host; init and toggle counts shortened
`timescale 1ns/1ps
`default_nettype none
module operating_mode_controller_test;
   import omc_pkg::*;
   localparam int unsigned INIT = 20;
   logic clk_sys_i = 1'b0;
   logic srst_i = 1'b1;
   logic [NCH-1:0] din = '0, ol = '0, uv = '0, ot = '0, lat = '0, w, pwr, arst, wrst, sel;
   logic wake_n = 1'b0, fb = 1'b0, bat_ok = 1'b1, log_ok = 1'b1, sfail = 1'b0, stk = 1'b0;
   logic [AW-1:0] addr;
   logic [DW-1:0] wdata, rdata, d;
   logic wr, rd, ext, pwm, current_sense_output, maxoc, diag, blank, idone, pclr;
   omc_mode_t mode;
   int failures = 0, comparisons = 0, cycles = 0, pcl = 0;
   always #4 clk_sys_i = ~clk_sys_i;
   omc_top #(.INIT_CYC(INIT), .BLANK_CYC(10), .TOGGLE_CYC(50)) dut_u (
      .clk_sys_i(clk_sys_i), .srst_i(srst_i), .direct_control_inputs_i(din),
      .active_low_wake_pin_n_i(wake_n), .fallback_input_i(fb), .battery_por_ok_i(bat_ok),
      .logic_por_ok_i(log_ok), .spi_fail_i(sfail), .spi_stuck_i(stk), .overload_i(ol),
      .undervoltage_i(uv), .overtemp_i(ot), .first_high_overcurrent_level_i(4'h0),
      .severe_short_i(4'h0), .reg_addr_i(addr), .reg_wdata_i(wdata), .reg_wr_i(wr),
      .reg_rd_i(rd), .reg_rdata_o(rdata), .mode_o(mode), .power_outputs_o(pwr),
      .external_switch_output_o(ext), .window_restart_o(wrst), .autorestart_o(arst),
      .pwm_enable_o(pwm), .current_sense_output_en_o(current_sense_output), .max_oc_profile_o(maxoc),
      .readout_select_bits_o(sel), .diag_avail_o(diag), .fault_suppress_o(blank),
      .init_done_o(idone), .por_clear_o(pclr));
   omc_host_model host (.clk_sys_i(clk_sys_i), .rdata_i(rdata), .addr_o(addr),
      .wdata_o(wdata), .wr_o(wr), .rd_o(rd));
   // ==========================================================================
   // checking and expectations
   task automatic chk(input logic [DW-1:0] got, input logic [DW-1:0] exp);
      comparisons++;
      if (got !== exp) begin
         failures++;
         $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   function automatic omc_mode_t exp_mode(input logic wake, input logic fail);
      return !wake ? MODE_SLEEP : (fail ? MODE_FAIL : MODE_NORMAL);
   endfunction
   task automatic wait_mode(input omc_mode_t m);
      int n;
      n = 0;
      while (mode !== m && n < 100) begin
         @(posedge clk_sys_i);
         n++;
      end
      chk(DW'(mode), DW'(m));
   endtask
   task automatic final_report();
      if (failures == 0 && comparisons > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask
   // a hang counts against the run
   always @(posedge clk_sys_i) begin
      cycles++;
      if (pclr === 1'b1) pcl++;
      if (cycles == 5000) begin
         failures++;
         final_report();
      end
   end
   // ==========================================================================
   // scenarios
   initial begin
      void'($urandom(67867));
      repeat (3) @(posedge clk_sys_i);
      srst_i <= 1'b0;
      wait_mode(MODE_SLEEP);
      chk({ext, pwr}, 0);
      din <= 4'h1 << ($urandom % 4);
      wait_mode(exp_mode(1'b1, 1'b0));
      din <= '0;
      wait_mode(exp_mode(1'b0, 1'b0));
      wake_n <= 1'b1; // supplies are already up
      wait_mode(MODE_NORMAL);
      chk({blank, idone}, 2'b10);
      repeat (INIT + 4) @(posedge clk_sys_i);
      chk(idone, 1'b1);
      repeat (6) begin
         d = $urandom;
         host.wr(REG_CHAN_ON, d);
         repeat (2) @(posedge clk_sys_i);
         chk({pwm, ext, pwr}, {1'b1, d[4:0]});
      end
      host.wr(REG_IN_EN, 32'hf);
      din <= NCH'($urandom);
      repeat (8) @(posedge clk_sys_i);
      chk(pwr, d[NCH-1:0] | din);
      din <= '0;
      host.rd(8'h3c, d);
      chk(d, 0); // unmapped place reads zero
      for (int c = 0; c < 2; c++) begin
         d = $urandom;
         host.wr(REG_SEL, d);
         if (c == 0) fb <= 1'b1;
         else {sfail, stk} <= 2'b11;
         wait_mode(exp_mode(1'b1, 1'b1));
         chk({maxoc, current_sense_output, pwm, ext, pwr}, 8'h80);
         chk({diag, sel}, {c == 0, d[SEL_W-1:0]});
         repeat (4) begin
            w = NCH'($urandom);
            d = DW'(w & ~din);
            din <= w;
            if (c == 1) ot <= NCH'($urandom);
            repeat (6) @(posedge clk_sys_i);
            chk(wrst, d);
            lat = lat | ot;
            repeat (2) @(posedge clk_sys_i);
            chk({diag, pwr}, {c == 0, din & ~lat});
            ol <= NCH'($urandom);
            uv <= NCH'($urandom);
            repeat (4) @(posedge clk_sys_i);
            chk(arst, (ol | uv) & ~lat);
         end
         // a toggle pair while the cause stands must not end fail
         host.toggle_pair();
         repeat (4) @(posedge clk_sys_i);
         chk(DW'(mode), DW'(MODE_FAIL));
         {fb, sfail, stk, ot, din, ol, uv} <= '0;
         repeat (8) @(posedge clk_sys_i);
         host.toggle_pair();
         wait_mode(MODE_NORMAL);
         chk({ext, pwr}, 0);
         host.rd(REG_STATUS, d);
         chk(d[ST_RCF:ST_DSF], 2'b11);
         host.rd(REG_STATUS, d);
         chk(d[ST_RCF], 1'b0);
      end
      log_ok <= 1'b0;
      repeat (8) @(posedge clk_sys_i);
      host.rd(REG_STATUS, d);
      chk(d, 0);
      wake_n <= 1'b0;
      wait_mode(MODE_SLEEP);
      bat_ok <= 1'b0;
      wait_mode(MODE_OFF);
      chk(pcl, 4);
      final_report();
   end
endmodule
`default_nettype wire
